// ===== src/opps_pkg.sv
// Purpose: shared constants, types and helpers for the output pin sharing
// Assumes: one 200 MHz processing clock on both ends
// Notes: shared pin indices give the serial-mode meaning of each pin
package opps_pkg;
   // width of the shared pin group and of a parallel sample word
   localparam int unsigned PIN_W = 16;
   // serial-mode role of each shared pin
   localparam int unsigned P_SCLK = 15;
   localparam int unsigned P_SDI = 14;
   localparam int unsigned P_SDO = 13;
   localparam int unsigned P_FS = 12;
   localparam int unsigned P_FE = 11;
   localparam int unsigned P_SBM = 10;
   localparam int unsigned P_WL1 = 9;
   localparam int unsigned P_WL0 = 8;
   localparam int unsigned P_AD = 7;
   localparam int unsigned P_NC_HI = 6;
   localparam int unsigned P_NC_LO = 4;
   localparam int unsigned P_DIV_HI = 3;
   localparam int unsigned P_DIV_LO = 0;
   // bit counter width: up to two 32-bit words in one slot
   localparam int unsigned CNT_W = 7;
   // strap and tag levels
   localparam logic SEL_PAR = 1'b1;
   localparam logic SBM_MASTER = 1'b1;
   localparam logic TAG_CHAN_A = 1'b1;
   localparam logic TAG_INPHASE = 1'b1;
   // word length strap codes
   localparam logic [1:0] WL_16 = 2'h0;
   localparam logic [1:0] WL_24 = 2'h1;
   localparam logic [1:0] WL_32 = 2'h2;
   localparam logic [1:0] WL_BAD = 2'h3;
   // serial word lengths in bits
   localparam logic [CNT_W-1:0] LEN_16 = 7'h10;
   localparam logic [CNT_W-1:0] LEN_24 = 7'h18;
   localparam logic [CNT_W-1:0] LEN_32 = 7'h20;
   // divide value zero means divide by two
   localparam logic [3:0] DIV_ZERO = 4'h0;
   localparam logic [3:0] DIV_MIN_HALF = 4'h1;

   // serial time-slot progress
   typedef enum logic [1:0] {OPPS_IDLE, OPPS_ARMED, OPPS_ACTIVE} opps_slot_t;

   // bits per serial word; the disallowed code falls back to 16
   function automatic logic [CNT_W-1:0] opps_word_bits(input logic [1:0] wl);
      case (wl)
         WL_24: opps_word_bits = LEN_24;
         WL_32: opps_word_bits = LEN_32;
         default: opps_word_bits = LEN_16;
      endcase
   endfunction : opps_word_bits

   // processing clocks per serial clock half period
   function automatic logic [3:0] opps_div_half(input logic [3:0] div);
      opps_div_half = (div == DIV_ZERO) ? DIV_MIN_HALF : div;
   endfunction : opps_div_half
endpackage : opps_pkg

// ===== src/opps_if.sv
// Purpose: pin bundle between the receive processor and its receiver
// Assumes: each party drives a shared pin only with its enable low
// Notes: an undriven shared pin reads low, as with a weak pull-down
`timescale 1ns/100ps
interface opps_if;
   logic reset_n; // device reset pin, active low, driven by host
   logic port_sel; // output port select strap, driven by host
   logic [opps_pkg::PIN_W-1:0] dev_out; // device drive values
   logic [opps_pkg::PIN_W-1:0] dev_oe_n; // device enables, low drives
   logic [opps_pkg::PIN_W-1:0] host_out; // host drive values
   logic [opps_pkg::PIN_W-1:0] host_oe_n; // host enables, low drives
   logic [opps_pkg::PIN_W-1:0] shared_lvl; // resolved wire level
   logic sample_valid_flag; // parallel word qualifier
   logic channel_a_tag; // 1 for channel A
   logic inphase_tag; // 1 for in-phase

   // resolve each shared wire; device wins if both drive by mistake
   always_comb
   begin
      for (int i = 0; i < opps_pkg::PIN_W; i++)
      begin
         if (!dev_oe_n[i])
            shared_lvl[i] = dev_out[i];
         else if (!host_oe_n[i])
            shared_lvl[i] = host_out[i];
         else
            shared_lvl[i] = 1'b0;
      end
   end

   modport device (
      input reset_n, port_sel, shared_lvl,
      output dev_out, dev_oe_n, sample_valid_flag, channel_a_tag, inphase_tag
   );
   modport host (
      input shared_lvl, sample_valid_flag, channel_a_tag, inphase_tag,
      output reset_n, port_sel, host_out, host_oe_n
   );
endinterface : opps_if

// ===== src/opps_clk_div.sv
// Purpose: enable pulse every half period of a serial clock
// Assumes: half period given in processing clocks, at least one
// Notes: the caller toggles its serial clock on each tick
`timescale 1ns/100ps
module opps_clk_div (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // control
   input wire logic en_i,
   input wire logic [3:0] half_i,
   // tick
   output logic tick_o
);
   import opps_pkg::*;

   logic [3:0] cnt_q, cnt_d; // cycles into the current half period
   logic tick_q, tick_d; // registered tick

   // count up to half minus one, then pulse and wrap
   always_comb
   begin
      cnt_d = cnt_q;
      tick_d = 1'b0;
      if (!en_i)
         cnt_d = 4'h0;
      else if (cnt_q >= half_i - DIV_MIN_HALF)
      begin
         cnt_d = 4'h0;
         tick_d = 1'b1;
      end
      else
         cnt_d = cnt_q + 4'h1;
   end

   // registers only
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_q <= 4'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;
endmodule : opps_clk_div

// ===== src/opps_device.sv
// Purpose: receive processor end of the shared output pin group
// Assumes: host keeps straps static and pins 6..4 open in serial mode
// Notes: every pin leaves through one register stage
// Functional notes
// - port select high parallel, low serial
// - sixteen-bit parallel word, pin 15 MSB
// - data-valid flag qualifies parallel word
// - channel tag: 1 channel A, 0 B
// - phase tag: 1 in-phase, 0 quadrature
// - master drives serial clock, cascade receives
// - frame sync output as master, input cascade
// - serial in, tristate out, frame end output
// - host holds word length, append straps static
// - host drives four-bit clock divide value
// - host leaves pins six to four open
// - reset pin active low holds logic
// - word length 16, 24, 32; 11 disallowed
// - master clock is clock over twice divide
`timescale 1ns/100ps
module opps_device (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // pins
   opps_if.device pins,
   // samples from the signal chain
   input wire logic smp_valid_i,
   input wire logic [opps_pkg::PIN_W-1:0] smp_data_i,
   input wire logic smp_chan_a_i,
   input wire logic smp_inphase_i,
   // status
   output logic par_mode_o,
   output logic in_reset_o,
   output logic wl_bad_o,
   output logic [opps_pkg::PIN_W-1:0] ctrl_word_o
);
   import opps_pkg::*;

   // pin synchronisers; stage one is read only by stage two
   logic rstn_s1_q, rstn_s2_q;
   logic sel_s1_q, sel_s2_q;
   logic [PIN_W-1:0] pin_s1_q, pin_s2_q;
   logic sclk_prev_q; // last synced cascade clock level

   // mode and slot state
   logic par_q, par_d; // latched port choice
   opps_slot_t slot_q, slot_d;
   logic [CNT_W-1:0] bit_q, bit_d; // bit index inside the slot
   logic [PIN_W-1:0] word_q, word_d; // newest sample held
   logic [PIN_W-1:0] tx_q, tx_d; // word being shifted
   logic pend_q, pend_d; // held word not yet sent
   logic sclk_q, sclk_d; // master serial clock
   logic fs_q, fs_d; // master frame sync
   logic fe_q, fe_d; // frame end level
   logic sdo_q, sdo_d; // serial data bit
   logic [PIN_W-1:0] ctrl_q, ctrl_d; // bits shifted in on serial input
   logic chan_q, chan_d;
   logic iq_q, iq_d;
   logic dv_q, dv_d;
   logic [PIN_W-1:0] out_q, out_d;
   logic [PIN_W-1:0] oe_n_q, oe_n_d;

   // decoded straps and edges
   logic pin_rst; // reset pin held low
   logic ser; // serial port in use
   logic master;
   logic [1:0] wl;
   logic [CNT_W-1:0] slot_len;
   logic tick, rise, fall, fs_lvl;

   // returns bit k of the left-justified slot, padding with zeros
   function automatic logic slot_bit(input logic [PIN_W-1:0] w,
                                     input logic [CNT_W-1:0] k);
      if (k < CNT_W'(PIN_W))
         slot_bit = w[PIN_W-1-k];
      else
         slot_bit = 1'b0;
   endfunction : slot_bit

   // two flip-flops on every pin before any logic reads it
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rstn_s1_q <= 1'b0;
         rstn_s2_q <= 1'b0;
         sel_s1_q <= 1'b0;
         sel_s2_q <= 1'b0;
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         rstn_s1_q <= pins.reset_n;
         rstn_s2_q <= rstn_s1_q;
         sel_s1_q <= pins.port_sel;
         sel_s2_q <= sel_s1_q;
         pin_s1_q <= pins.shared_lvl;
         pin_s2_q <= pin_s1_q;
         sclk_prev_q <= pin_s2_q[P_SCLK];
      end
   end

   assign pin_rst = !rstn_s2_q;
   assign ser = (par_q != SEL_PAR) && !pin_rst;
   assign master = ser && (pin_s2_q[P_SBM] == SBM_MASTER);
   assign wl = {pin_s2_q[P_WL1], pin_s2_q[P_WL0]};
   // the appended word is all zeros: no register reads in this block
   assign slot_len = pin_s2_q[P_AD] ? (opps_word_bits(wl) << 1)
                                    : opps_word_bits(wl);

   // half period from the divide pins, zero treated as one
   opps_clk_div u_div (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(master),
      .half_i(opps_div_half(pin_s2_q[P_DIV_HI:P_DIV_LO])),
      .tick_o(tick)
   );

   // master uses its own clock; cascade uses the synced pin edges
   always_comb
   begin
      if (master)
      begin
         rise = tick && !sclk_q;
         fall = tick && sclk_q;
         fs_lvl = fs_q;
      end
      else
      begin
         rise = ser && pin_s2_q[P_SCLK] && !sclk_prev_q;
         fall = ser && !pin_s2_q[P_SCLK] && sclk_prev_q;
         fs_lvl = pin_s2_q[P_FS];
      end
   end

   // next state of the port; pin reset latches the strap and clears the slot state, keeping the held word and tags
   always_comb
   begin
      par_d = par_q;
      slot_d = slot_q;
      bit_d = bit_q;
      word_d = word_q;
      tx_d = tx_q;
      pend_d = pend_q;
      sclk_d = sclk_q;
      fs_d = fs_q;
      fe_d = fe_q;
      sdo_d = sdo_q;
      ctrl_d = ctrl_q;
      chan_d = chan_q;
      iq_d = iq_q;
      dv_d = 1'b0;
      if (pin_rst)
      begin
         par_d = sel_s2_q;
         slot_d = OPPS_IDLE;
         bit_d = '0;
         pend_d = 1'b0;
         sclk_d = 1'b0;
         fs_d = 1'b0;
         fe_d = 1'b0;
         sdo_d = 1'b0;
         ctrl_d = '0;
      end
      else
      begin
         // master clock toggles on every divider tick
         if (master && tick)
            sclk_d = !sclk_q;
         // master frame sync: one serial clock high before a slot
         if (master && rise)
            fs_d = !fs_q && pend_q && (slot_q == OPPS_IDLE);
         // serial input sampled on falling edges during a slot
         if (fall && (slot_q == OPPS_ACTIVE))
            ctrl_d = {ctrl_q[PIN_W-2:0], pin_s2_q[P_SDI]};
         case (slot_q)
            OPPS_IDLE:
            begin
               if (fall && fs_lvl)
                  slot_d = OPPS_ARMED;
            end
            OPPS_ARMED:
            begin
               if (rise)
               begin
                  slot_d = OPPS_ACTIVE;
                  bit_d = '0;
                  tx_d = word_q;
                  pend_d = 1'b0;
                  sdo_d = slot_bit(word_q, '0);
                  fe_d = (slot_len == CNT_W'(1));
               end
            end
            OPPS_ACTIVE:
            begin
               if (rise && (bit_q == slot_len - CNT_W'(1)))
               begin
                  slot_d = OPPS_IDLE;
                  fe_d = 1'b0;
                  sdo_d = 1'b0;
               end
               else if (rise)
               begin
                  bit_d = bit_q + CNT_W'(1);
                  sdo_d = slot_bit(tx_q, bit_q + CNT_W'(1));
                  fe_d = (bit_q + CNT_W'(2) == slot_len);
               end
            end
            default: slot_d = OPPS_IDLE;
         endcase
         // a new sample wins over the clear of the pending flag
         if (smp_valid_i)
         begin
            word_d = smp_data_i;
            pend_d = 1'b1;
            chan_d = (smp_chan_a_i == TAG_CHAN_A);
            iq_d = (smp_inphase_i == TAG_INPHASE);
            dv_d = (par_q == SEL_PAR);
         end
      end
   end

   // pin values and enables from the current state
   always_comb
   begin
      out_d = '0;
      oe_n_d = '1;
      if (pin_rst)
         oe_n_d = '1; // straps may be on the pins, so drive nothing
      else if (par_q == SEL_PAR)
      begin
         out_d = (smp_valid_i) ? smp_data_i : out_q;
         oe_n_d = '0;
      end
      else
      begin
         out_d[P_SDO] = sdo_q;
         out_d[P_FE] = fe_q;
         out_d[P_SCLK] = sclk_q;
         out_d[P_FS] = fs_q;
         oe_n_d[P_SDO] = (slot_q != OPPS_ACTIVE);
         oe_n_d[P_FE] = 1'b0;
         oe_n_d[P_SCLK] = !master;
         oe_n_d[P_FS] = !master;
      end
   end

   // registers only; async reset takes constants
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         par_q <= SEL_PAR;
         slot_q <= OPPS_IDLE;
         bit_q <= '0;
         word_q <= '0;
         tx_q <= '0;
         pend_q <= 1'b0;
         sclk_q <= 1'b0;
         fs_q <= 1'b0;
         fe_q <= 1'b0;
         sdo_q <= 1'b0;
         ctrl_q <= '0;
         chan_q <= 1'b0;
         iq_q <= 1'b0;
         dv_q <= 1'b0;
         out_q <= '0;
         oe_n_q <= '1;
      end
      else
      begin
         par_q <= par_d;
         slot_q <= slot_d;
         bit_q <= bit_d;
         word_q <= word_d;
         tx_q <= tx_d;
         pend_q <= pend_d;
         sclk_q <= sclk_d;
         fs_q <= fs_d;
         fe_q <= fe_d;
         sdo_q <= sdo_d;
         ctrl_q <= ctrl_d;
         chan_q <= chan_d;
         iq_q <= iq_d;
         dv_q <= dv_d;
         out_q <= out_d;
         oe_n_q <= oe_n_d;
      end
   end

   // status flops
   logic wl_bad_q;
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         wl_bad_q <= 1'b0;
      else
         wl_bad_q <= ser && (wl == WL_BAD);
   end

   assign pins.dev_out = out_q;
   assign pins.dev_oe_n = oe_n_q;
   assign pins.sample_valid_flag = dv_q;
   assign pins.channel_a_tag = chan_q;
   assign pins.inphase_tag = iq_q;
   assign par_mode_o = par_q;
   assign in_reset_o = rstn_s2_q == 1'b0 ? 1'b1 : 1'b0;
   assign wl_bad_o = wl_bad_q;
   assign ctrl_word_o = ctrl_q;
endmodule : opps_device

// ===== src/opps_host.sv
// Purpose: receiver end: straps, reset pin, capture of output words
// Assumes: configuration inputs stay static outside reset
// Notes: in cascade mode this end makes the serial clock and frame sync
`timescale 1ns/100ps
module opps_host (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // pins
   opps_if.host pins,
   // configuration
   input wire logic reset_req_i,
   input wire logic par_sel_i,
   input wire logic master_sel_i,
   input wire logic [1:0] word_len_i,
   input wire logic append_i,
   input wire logic [3:0] divide_i,
   input wire logic ctrl_bit_i,
   input wire logic fs_req_i,
   // received word
   output logic rx_valid_o,
   output logic [opps_pkg::PIN_W-1:0] rx_data_o,
   output logic rx_chan_a_o,
   output logic rx_inphase_o
);
   import opps_pkg::*;

   // synchronisers for everything the device drives
   logic [PIN_W-1:0] pin_s1_q, pin_s2_q;
   logic [2:0] tag_s1_q, tag_s2_q;
   logic sclk_prev_q;
   // state
   logic rstn_q, sel_q, hsclk_q, hsclk_d, hfs_q, hfs_d, fsp_q, fsp_d;
   logic on_q, on_d, val_q, val_d, ch_q, ch_d, iq_q, iq_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [PIN_W-1:0] sh_q, sh_d, dat_q, dat_d, out_q, out_d, oe_n_q, oe_n_d;
   logic tick, cascade, fall;

   assign cascade = !par_sel_i && (master_sel_i != SBM_MASTER);
   assign fall = !pin_s2_q[P_SCLK] && sclk_prev_q;

   // own serial clock for cascade mode
   opps_clk_div u_div (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(cascade),
      .half_i(opps_div_half(divide_i)),
      .tick_o(tick)
   );

   // capture, frame sync and pin drive
   always_comb
   begin
      hsclk_d = cascade ? (hsclk_q ^ tick) : 1'b0;
      fsp_d = fsp_q || fs_req_i;
      hfs_d = hfs_q;
      if (cascade && tick && !hsclk_q)
      begin
         hfs_d = fsp_q;
         fsp_d = fs_req_i;
      end
      on_d = on_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      dat_d = dat_q;
      ch_d = ch_q;
      iq_d = iq_q;
      val_d = 1'b0;
      if (par_sel_i && tag_s2_q[2])
      begin
         val_d = 1'b1;
         dat_d = pin_s2_q;
         ch_d = tag_s2_q[1];
         iq_d = tag_s2_q[0];
      end
      else if (!par_sel_i && fall && !on_q && pin_s2_q[P_FS])
      begin
         on_d = 1'b1;
         cnt_d = '0;
      end
      else if (!par_sel_i && fall && on_q)
      begin
         if (cnt_q < CNT_W'(PIN_W))
            sh_d = {sh_q[PIN_W-2:0], pin_s2_q[P_SDO]};
         cnt_d = cnt_q + CNT_W'(1);
         if (pin_s2_q[P_FE])
         begin
            on_d = 1'b0;
            val_d = 1'b1;
            dat_d = (cnt_q < CNT_W'(PIN_W)) ? sh_d : sh_q;
            ch_d = tag_s2_q[1];
            iq_d = tag_s2_q[0];
         end
      end
      out_d = '0;
      oe_n_d = '1;
      if (!par_sel_i)
      begin
         out_d[P_SDI] = ctrl_bit_i;
         out_d[P_SBM] = master_sel_i;
         out_d[P_WL1] = word_len_i[1];
         out_d[P_WL0] = word_len_i[0];
         out_d[P_AD] = append_i;
         out_d[P_DIV_HI:P_DIV_LO] = divide_i;
         out_d[P_SCLK] = hsclk_q;
         out_d[P_FS] = hfs_q;
         oe_n_d = '1;
         oe_n_d[P_SDI] = 1'b0;
         oe_n_d[P_SBM:P_AD] = '0;
         oe_n_d[P_DIV_HI:P_DIV_LO] = '0;
         oe_n_d[P_SCLK] = !cascade;
         oe_n_d[P_FS] = !cascade;
         oe_n_d[P_NC_HI:P_NC_LO] = '1;
      end
   end

   // registers; reset pin is held low while this end is in reset
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         tag_s1_q <= '0;
         tag_s2_q <= '0;
         sclk_prev_q <= 1'b0;
         rstn_q <= 1'b0;
         sel_q <= SEL_PAR;
         {hsclk_q, hfs_q, fsp_q, on_q, val_q, ch_q, iq_q} <= '0;
         cnt_q <= '0;
         {sh_q, dat_q, out_q} <= '0;
         oe_n_q <= '1;
      end
      else
      begin
         pin_s1_q <= pins.shared_lvl;
         pin_s2_q <= pin_s1_q;
         tag_s1_q <= {pins.sample_valid_flag, pins.channel_a_tag,
                      pins.inphase_tag};
         tag_s2_q <= tag_s1_q;
         sclk_prev_q <= pin_s2_q[P_SCLK];
         rstn_q <= !reset_req_i;
         sel_q <= par_sel_i;
         {hsclk_q, hfs_q, fsp_q, on_q, val_q, ch_q, iq_q} <=
            {hsclk_d, hfs_d, fsp_d, on_d, val_d, ch_d, iq_d};
         cnt_q <= cnt_d;
         {sh_q, dat_q, out_q} <= {sh_d, dat_d, out_d};
         oe_n_q <= oe_n_d;
      end
   end

   assign pins.reset_n = rstn_q;
   assign pins.port_sel = sel_q;
   assign pins.host_out = out_q;
   assign pins.host_oe_n = oe_n_q;
   assign rx_valid_o = val_q;
   assign rx_data_o = dat_q;
   assign rx_chan_a_o = ch_q;
   assign rx_inphase_o = iq_q;
endmodule : opps_host

// ===== verification/opps_props.sv
// Purpose: concurrent checks on the shared pin bundle
// Assumes: straps change only while the reset pin is held low
// Notes: mode is learned from port select during pin reset
`timescale 1ns/100ps
module opps_props (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // bundle signals
   input wire logic reset_n,
   input wire logic port_sel,
   input wire logic [opps_pkg::PIN_W-1:0] dev_out,
   input wire logic [opps_pkg::PIN_W-1:0] dev_oe_n,
   input wire logic [opps_pkg::PIN_W-1:0] shared_lvl,
   input wire logic sample_valid_flag
);
   import opps_pkg::*;
   logic mode_q; // port choice seen during pin reset
   logic [2:0] run_q; // cycles since pin reset release, saturating
   logic ser; // settled serial mode
   logic mst; // settled master with one-cycle half period
   // the settle count hides the two-flop reset sync in the device
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode_q <= SEL_PAR;
         run_q <= 3'h0;
      end
      else if (!reset_n)
      begin
         mode_q <= port_sel;
         run_q <= 3'h0;
      end
      else if (run_q != 3'h7)
         run_q <= run_q + 3'h1;
   end
   // straps move with the reset pin, so serial checks stop when it falls
   assign ser = reset_n && (run_q == 3'h7) && (mode_q != SEL_PAR);
   // divide 0 and 1 both give one mclk per half period
   assign mst = ser && shared_lvl[P_SBM] && (shared_lvl[3:1] == 3'h0);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // pin held low long enough to pass the sync
   sequence s_held_rst;
      !reset_n [*5];
   endsequence
   // high for one serial clock period, then low
   sequence s_two(s);
      s [*2] ##1 !s;
   endsequence
   a_straps_undriven:
   assert property (ser |-> &dev_oe_n[P_SBM:P_DIV_LO])
      else $error("device drives a strap pin in serial mode");
   a_word_on_pins:
   assert property (sample_valid_flag |->
      (dev_oe_n == '0) && (shared_lvl == dev_out))
      else $error("valid word not driven on all pins");
   a_valid_par_only:
   assert property (ser |-> !sample_valid_flag)
      else $error("data valid pulse in serial mode");
   a_quiet_in_reset:
   assert property (s_held_rst |-> !sample_valid_flag)
      else $error("data valid pulse during pin reset");
   a_clock_direction:
   assert property (ser |-> dev_oe_n[P_SCLK] == !shared_lvl[P_SBM])
      else $error("serial clock drive does not follow strap");
   a_sync_direction:
   assert property (ser |-> dev_oe_n[P_FS] == !shared_lvl[P_SBM])
      else $error("frame sync drive does not follow strap");
   a_end_with_data:
   assert property (ser && !dev_oe_n[P_FE] && dev_out[P_FE]
      |-> !dev_oe_n[P_SDO])
      else $error("frame end outside the serial slot");
   a_end_one_period:
   assert property (mst && $rose(dev_out[P_FE]) |-> s_two(dev_out[P_FE]))
      else $error("frame end not one serial clock long");
   a_sync_one_period:
   assert property (mst && $rose(dev_out[P_FS]) |-> s_two(dev_out[P_FS]))
      else $error("master frame sync not one serial clock long");
endmodule : opps_props

// ===== verification/test_output_port_pin_sharing.sv
// Purpose: self-checking bench joining both ends of the pin group
// Assumes: straps move only while the reset pin is held low, save port select in the reset hold test
// Notes: slot length is measured on the serial output enable
`timescale 1ns/100ps
module test_output_port_pin_sharing;
   import opps_pkg::*;
   // clock, reset and host configuration
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rq = 1'b1; // hold device reset pin low
   logic ps = 1'b1; // port select strap
   logic ms = 1'b0; // master strap
   logic ap = 1'b0; // append strap
   logic cb = 1'b1; // level on serial control input
   logic fq = 1'b0; // frame sync request, cascade only
   logic [1:0] wl = 2'h0; // word length strap
   logic [3:0] dv = 4'h1; // clock divide
   // samples into the device
   logic sv = 1'b0;
   logic sa = 1'b0;
   logic si = 1'b0;
   logic [PIN_W-1:0] sd = 16'h0;
   // observed status
   logic par_mode, in_rst, wl_bad, rxv, rxa, rxi;
   logic [PIN_W-1:0] ctrl_w, rxd;
   int fail_count = 0;
   int total_checks = 0;
   opps_if pins_if();
   opps_device i_opps_device (.mclk_i, .rst_i, .pins(pins_if),
      .smp_valid_i(sv), .smp_data_i(sd), .smp_chan_a_i(sa),
      .smp_inphase_i(si), .par_mode_o(par_mode), .in_reset_o(in_rst),
      .wl_bad_o(wl_bad), .ctrl_word_o(ctrl_w));
   opps_host i_opps_host (.mclk_i, .rst_i, .pins(pins_if),
      .reset_req_i(rq), .par_sel_i(ps), .master_sel_i(ms),
      .word_len_i(wl), .append_i(ap), .divide_i(dv), .ctrl_bit_i(cb),
      .fs_req_i(fq), .rx_valid_o(rxv), .rx_data_o(rxd),
      .rx_chan_a_o(rxa), .rx_inphase_o(rxi));
   opps_props i_opps_props (.mclk_i, .rst_i, .reset_n(pins_if.reset_n),
      .port_sel(pins_if.port_sel), .dev_out(pins_if.dev_out),
      .dev_oe_n(pins_if.dev_oe_n), .shared_lvl(pins_if.shared_lvl),
      .sample_valid_flag(pins_if.sample_valid_flag));
   // 200 MHz processing clock
   initial
   begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   // step past n edges, landing just after the last
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : cyc
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // straps only move while the pin reset is held
   task automatic pin_reset(input logic p, input logic m,
      input logic [1:0] w, input logic a, input logic [3:0] d);
      rq = 1'b1;
      {ps, ms, wl, ap, dv} = {p, m, w, a, d};
      cyc(5);
      rq = 1'b0;
      cyc(12);
   endtask : pin_reset
   // back-to-back words, every tag combination
   task automatic t_par;
      pin_reset(1'b1, 1'b0, 2'h0, 1'b0, 4'h1);
      check(par_mode, 1'b1);
      for (int i = 0; i < 5; i++)
      begin
         if (i > 0)
            check({pins_if.sample_valid_flag, pins_if.channel_a_tag,
               pins_if.inphase_tag, pins_if.shared_lvl},
               {1'b1, sa, si, sd});
         sv = (i < 4);
         sd = 16'h8001 << i;
         sa = ~sa;
         si = i[1];
         cyc(1);
      end
      check(pins_if.sample_valid_flag, 1'b0);
      cyc(2);
      check(rxv, 1'b1);
      check({rxd, rxa, rxi}, {16'h0008, 1'b0, 1'b1});
      cyc(1);
      check(rxv, 1'b0);
      $display("parallel test done");
   endtask : t_par
   // samples refused in reset, choice frozen after release
   task automatic t_hold;
      rq = 1'b1;
      cyc(5);
      check(in_rst, 1'b1);
      sv = 1'b1;
      cyc(1);
      sv = 1'b0;
      check(pins_if.sample_valid_flag, 1'b0);
      rq = 1'b0;
      cyc(6);
      ps = 1'b0;
      cyc(10);
      check({in_rst, par_mode}, 2'h1);
      sv = 1'b1;
      cyc(1);
      sv = 1'b0;
      check(pins_if.sample_valid_flag, 1'b1);
      ps = 1'b1;
      $display("reset hold test done");
   endtask : t_hold
   // one serial slot; length counted while the output is enabled
   task automatic t_ser(input logic m, input logic [1:0] w,
      input logic a, input logic [3:0] d);
      int n;
      int h;
      int b;
      h = (d == 4'h0) ? 1 : int'(d);
      b = (w == 2'h1) ? 24 : (w == 2'h2) ? 32 : 16;
      pin_reset(1'b0, m, w, a, d);
      check({par_mode, wl_bad}, {1'b0, w == 2'h3});
      check(pins_if.shared_lvl[P_NC_HI:P_NC_LO], 3'h0);
      sv = 1'b1;
      sd = 16'hc3a5 ^ {w, 14'h0};
      cyc(1);
      sv = 1'b0;
      fq = !m;
      cyc(1);
      fq = 1'b0;
      n = 0;
      while (pins_if.dev_oe_n[P_SDO] === 1'b1 && n < 400)
      begin
         n++;
         cyc(1);
      end
      check(pins_if.shared_lvl[P_SDO], sd[15]);
      n = 0;
      while (pins_if.dev_oe_n[P_SDO] === 1'b0 && n < 400)
      begin
         n++;
         cyc(1);
      end
      check(n, b * (a ? 4 : 2) * h);
      cyc(8);
      check(ctrl_w, 16'hffff);
      if (w == 2'h0 && !a)
         check(rxd, sd);
      $display("serial test done");
   endtask : t_ser
   // main sequence
   initial
   begin
      cyc(5);
      rst_i = 1'b0;
      t_par();
      t_hold();
      t_ser(1'b1, 2'h0, 1'b0, 4'h1);
      t_ser(1'b1, 2'h1, 1'b1, 4'h2);
      t_ser(1'b1, 2'h2, 1'b0, 4'h0);
      t_ser(1'b1, 2'h3, 1'b0, 4'h1);
      // cascade half period must cover the four-clock sync round trip
      t_ser(1'b0, 2'h0, 1'b0, 4'h4);
      wrap_up();
   end
   // the tests take several hundred cycles; this span is far beyond
   initial
   begin
      #400000;
      fail_count++;
      wrap_up();
   end
endmodule : test_output_port_pin_sharing
